/* core/pas_sequencer.sv */
// Pump sequencer: auto-cleaning, jockey pump and priming pump with AXI4-Lite registers
// Behaviour
// - With cleaning enabled, a rising selected activation input starts the drive and the cleaning sequence.
// - Releasing the activation input before the last cycle ends aborts the sequence at once.
// - The forward/reverse cycle repeats a programmed count of 1 to 100, default 5.
// - Each cycle holds the forward frequency (up to 50.00 Hz) for the forward time (up to 320.00 s).
// - Jockey mode 0 is unused, mode 1 runs the pump through sleep, mode 2 follows feedback levels in sleep.
// - In level mode during sleep the jockey pump starts when feedback falls below the start level.
// - In level mode during sleep the jockey pump stops when feedback rises above the stop level.
// - The jockey pump stops whenever the controller wakes, whatever the feedback.
// - With priming enabled the priming pump runs for the priming time (0.0 to 320.0 s, default 3.0) first.
`timescale 1ns/100ps
`include "pas_params.svh"
module pas_sequencer #(
    parameter int TICK_CYCLES = `PAS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Drive inputs
    input wire logic [3:0] dig_in_i,
    input wire logic run_cmd_i,
    input wire logic pid_sleep_i,
    input wire logic [13:0] feedback_i,
    // Drive and pump outputs
    output logic drive_run_o,
    output logic clean_active_o,
    output logic [12:0] freq_ref_o,
    output logic reverse_o,
    output logic ramp_sel_o,
    output logic [11:0] ramp_acc_o,
    output logic [11:0] ramp_dec_o,
    output logic jockey_o,
    output logic prime_pump_o,
    output logic main_run_o
);
    localparam logic [21:0] TICK_LAST = 22'(TICK_CYCLES - 1);
    pas_pkg::pas_state_t q, n;
    logic trig;
    logic [1:0] mode;
    // Register word at a byte address; reads and write merges share it, so the two cannot drift apart
    function automatic logic [31:0] word_at(input pas_pkg::pas_state_t s, input logic [7:0] a);
        case (a)
            `PAS_ADDR_CTRL: return {26'h0, s.ctrl};
            `PAS_ADDR_CYCLES: return {25'h0, s.cycles};
            `PAS_ADDR_FWD_FREQ: return {19'h0, s.fwd_freq};
            `PAS_ADDR_FWD_TIME: return {17'h0, s.fwd_time};
            `PAS_ADDR_REV_FREQ: return {19'h0, s.rev_freq};
            `PAS_ADDR_REV_TIME: return {17'h0, s.rev_time};
            `PAS_ADDR_ACC_TIME: return {20'h0, s.acc_time};
            `PAS_ADDR_DEC_TIME: return {20'h0, s.dec_time};
            `PAS_ADDR_JSTART: return {18'h0, s.jstart};
            `PAS_ADDR_JSTOP: return {18'h0, s.jstop};
            `PAS_ADDR_PRIME_TIME: return {20'h0, s.prime_time};
            `PAS_ADDR_STATUS: return {15'h0, s.cyc_done, s.pst, s.cst, s.jockey, s.sleep_s2, s.run_s2,
                s.din_s2[s.ctrl[`PAS_CTRL_TRIG_LSB +: 2]]};
            default: return 32'h0;
        endcase
    endfunction : word_at
    assign trig = q.din_s2[q.ctrl[`PAS_CTRL_TRIG_LSB +: 2]];
    assign mode = q.ctrl[`PAS_CTRL_MODE_LSB +: 2];
    // Next state of bus, registers and sequencers
    always_comb begin
        logic [31:0] m;
        logic [31:0] lanes;
        logic hit;
        m = 32'h0;
        lanes = 32'h0;
        hit = 1'b1;
        n = q;
        n.din_s1 = dig_in_i;
        n.din_s2 = q.din_s1;
        n.run_s1 = run_cmd_i;
        n.run_s2 = q.run_s1;
        n.sleep_s1 = pid_sleep_i;
        n.sleep_s2 = q.sleep_s1;
        n.fb = feedback_i;
        n.trig_prev = trig;
        // Address and data may arrive in either order
        if (s_axi_awvalid_i && q.awready) begin
            n.aw_held = 1'b1;
            n.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wready) begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata_i;
            n.wstrb = s_axi_wstrb_i;
        end
        n.bvalid = q.bvalid && !s_axi_bready_i;
        // Writes clamp to the legal range so the sequencers never see nonsense
        if (q.aw_held && q.w_held && !q.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            // Strobed lanes take new data, the others keep the old word
            lanes = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
            m = (q.wdata & lanes) | (word_at(q, q.awaddr) & ~lanes);
            case (q.awaddr)
                `PAS_ADDR_CTRL: n.ctrl = (m[4:3] == 2'h3) ? {m[5], 2'h0, m[2:0]} : m[5:0];
                `PAS_ADDR_CYCLES: n.cycles = (m > 32'(`PAS_MAX_CYCLES)) ? `PAS_MAX_CYCLES :
                    (m[6:0] < `PAS_MIN_CYCLES) ? `PAS_MIN_CYCLES : m[6:0];
                `PAS_ADDR_FWD_FREQ: n.fwd_freq = (m > 32'(`PAS_MAX_FREQ)) ? `PAS_MAX_FREQ : m[12:0];
                `PAS_ADDR_FWD_TIME: n.fwd_time = (m > 32'(`PAS_MAX_TIME)) ? `PAS_MAX_TIME : m[14:0];
                `PAS_ADDR_REV_FREQ: n.rev_freq = (m > 32'(`PAS_MAX_FREQ)) ? `PAS_MAX_FREQ : m[12:0];
                `PAS_ADDR_REV_TIME: n.rev_time = (m > 32'(`PAS_MAX_TIME)) ? `PAS_MAX_TIME : m[14:0];
                `PAS_ADDR_ACC_TIME: n.acc_time = (m > 32'(`PAS_MAX_RAMP)) ? `PAS_MAX_RAMP :
                    (m[11:0] < `PAS_MIN_RAMP) ? `PAS_MIN_RAMP : m[11:0];
                `PAS_ADDR_DEC_TIME: n.dec_time = (m > 32'(`PAS_MAX_RAMP)) ? `PAS_MAX_RAMP :
                    (m[11:0] < `PAS_MIN_RAMP) ? `PAS_MIN_RAMP : m[11:0];
                `PAS_ADDR_JSTART: n.jstart = (m > 32'(`PAS_MAX_LEVEL)) ? `PAS_MAX_LEVEL : m[13:0];
                `PAS_ADDR_JSTOP: n.jstop = (m > 32'(`PAS_MAX_LEVEL)) ? `PAS_MAX_LEVEL : m[13:0];
                `PAS_ADDR_PRIME_TIME: n.prime_time = (m > 32'(`PAS_MAX_PRIME)) ? `PAS_MAX_PRIME : m[11:0];
                default: hit = 1'b0; // Status and holes take no write
            endcase
            n.bresp = hit ? 2'h0 : 2'h2;
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;
        // Read answers one cycle after the address is taken; holes and odd addresses give SLVERR
        n.rvalid = q.rvalid && !s_axi_rready_i;
        if (s_axi_arvalid_i && q.arready) begin
            n.rvalid = 1'b1;
            n.rdata = word_at(q, s_axi_araddr_i);
            n.rresp = (s_axi_araddr_i[1:0] != 2'h0 || s_axi_araddr_i > `PAS_ADDR_STATUS) ? 2'h2 : 2'h0;
        end
        n.arready = !n.rvalid;
        // Seconds timebase: one tick every 10 ms
        n.tick = (q.div == TICK_LAST);
        n.div = n.tick ? 22'h0 : q.div + 22'h1;
        // Cleaning sequencer; release aborts regardless of the tick
        case (q.cst)
            pas_pkg::CL_IDLE: begin
                n.timer = 15'h0;
                n.cyc_done = 7'h0;
                if (q.ctrl[`PAS_CTRL_CLEAN_EN] && trig && !q.trig_prev) begin
                    n.cst = pas_pkg::CL_FWD;
                end
            end
            pas_pkg::CL_FWD: begin
                if (!trig) begin
                    n.cst = pas_pkg::CL_IDLE;
                end else if (q.timer >= q.fwd_time) begin
                    n.cst = pas_pkg::CL_REV;
                    n.timer = 15'h0;
                end else if (q.tick) begin
                    n.timer = q.timer + 15'h1;
                end
            end
            pas_pkg::CL_REV: begin
                if (!trig) begin
                    n.cst = pas_pkg::CL_IDLE;
                end else if (q.timer >= q.rev_time) begin
                    n.timer = 15'h0;
                    n.cyc_done = q.cyc_done + 7'h1;
                    n.cst = (q.cyc_done + 7'h1 >= q.cycles) ? pas_pkg::CL_IDLE : pas_pkg::CL_FWD;
                end else if (q.tick) begin
                    n.timer = q.timer + 15'h1;
                end
            end
            default: n.cst = pas_pkg::CL_IDLE;
        endcase
        n.clean_act = (n.cst != pas_pkg::CL_IDLE);
        n.drive_run = n.clean_act;
        n.rev_out = (n.cst == pas_pkg::CL_REV);
        n.freq_out = (n.cst == pas_pkg::CL_FWD) ? q.fwd_freq : n.rev_out ? q.rev_freq : 13'h0;
        n.ramp_sel = n.clean_act;
        n.ramp_acc = q.acc_time;
        n.ramp_dec = q.dec_time;
        // Jockey pump: wake always wins; levels hold between thresholds
        if (!q.sleep_s2) begin
            n.jockey = 1'b0;
        end else begin
            case (mode)
                2'h1: n.jockey = 1'b1;
                2'h2: begin
                    if (q.fb < q.jstart) begin
                        n.jockey = 1'b1;
                    end else if (q.fb > q.jstop) begin
                        n.jockey = 1'b0;
                    end
                end
                default: n.jockey = 1'b0;
            endcase
        end
        // Priming ahead of the main pump; priming time is in 0.1 s, the timer in ticks
        case (q.pst)
            pas_pkg::PR_IDLE: begin
                n.ptimer = 16'h0;
                if (q.run_s2) begin
                    n.pst = q.ctrl[`PAS_CTRL_PRIME_EN] ? pas_pkg::PR_PRIME : pas_pkg::PR_RUN;
                end
            end
            pas_pkg::PR_PRIME: begin
                if (!q.run_s2) begin
                    n.pst = pas_pkg::PR_IDLE;
                end else if (q.ptimer >= 16'(q.prime_time * `PAS_PRIME_SCALE)) begin
                    n.pst = pas_pkg::PR_RUN;
                end else if (q.tick) begin
                    n.ptimer = q.ptimer + 16'h1;
                end
            end
            pas_pkg::PR_RUN: n.pst = q.run_s2 ? pas_pkg::PR_RUN : pas_pkg::PR_IDLE;
            default: n.pst = pas_pkg::PR_IDLE;
        endcase
        n.prime = (n.pst == pas_pkg::PR_PRIME);
        n.main_run = (n.pst == pas_pkg::PR_RUN);
    end
    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
            q.cycles <= `PAS_RST_CYCLES;
            q.fwd_freq <= `PAS_RST_FREQ;
            q.rev_freq <= `PAS_RST_FREQ;
            q.fwd_time <= `PAS_RST_FWD_TIME;
            q.rev_time <= `PAS_RST_REV_TIME;
            q.acc_time <= `PAS_RST_RAMP;
            q.dec_time <= `PAS_RST_RAMP;
            q.ramp_acc <= `PAS_RST_RAMP;
            q.ramp_dec <= `PAS_RST_RAMP;
            q.prime_time <= `PAS_RST_PRIME;
            q.cst <= pas_pkg::CL_IDLE;
            q.pst <= pas_pkg::PR_IDLE;
        end else begin
            q <= n;
        end
    end
    // Outputs straight from the state register
    assign s_axi_awready_o = q.awready;
    assign s_axi_wready_o = q.wready;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = q.arready;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign drive_run_o = q.drive_run;
    assign clean_active_o = q.clean_act;
    assign freq_ref_o = q.freq_out;
    assign reverse_o = q.rev_out;
    assign ramp_sel_o = q.ramp_sel;
    assign ramp_acc_o = q.ramp_acc;
    assign ramp_dec_o = q.ramp_dec;
    assign jockey_o = q.jockey;
    assign prime_pump_o = q.prime;
    assign main_run_o = q.main_run;
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_clean_start: assert property (q.cst == pas_pkg::CL_IDLE && q.ctrl[0] && trig && !q.trig_prev
        |=> q.cst == pas_pkg::CL_FWD && drive_run_o) else $error("cleaning did not start");
    a_clean_abort: assert property (q.cst != pas_pkg::CL_IDLE && !trig
        |=> q.cst == pas_pkg::CL_IDLE && !drive_run_o) else $error("cleaning not aborted");
    a_cycle_count: assert property (q.cst != pas_pkg::CL_IDLE |-> q.cyc_done < q.cycles)
        else $error("too many cleaning cycles");
    a_fwd_phase: assert property (q.cst == pas_pkg::CL_FWD
        |-> freq_ref_o == $past(q.fwd_freq) && !reverse_o && q.timer <= q.fwd_time)
        else $error("forward phase wrong");
    a_rev_follows: assert property (q.cst == pas_pkg::CL_REV |-> $past(q.cst) != pas_pkg::CL_IDLE
        && reverse_o && ramp_sel_o) else $error("reverse phase wrong");
    a_jockey_cont: assert property (mode == 2'h1 && q.sleep_s2 |=> jockey_o)
        else $error("jockey not continuous");
    a_jockey_start: assert property (mode == 2'h2 && q.sleep_s2 && q.fb < q.jstart |=> jockey_o)
        else $error("jockey not started");
    a_jockey_stop: assert property (mode == 2'h2 && q.sleep_s2 && q.fb >= q.jstart && q.fb > q.jstop
        |=> !jockey_o) else $error("jockey not stopped");
    a_jockey_wake: assert property (!q.sleep_s2 |=> !jockey_o) else $error("jockey runs awake");
    a_prime_first: assert property ($rose(main_run_o) && $past(q.pst) == pas_pkg::PR_IDLE
        |-> !$past(q.ctrl[5])) else $error("main pump started before priming");
    a_clean_disabled: assert property (q.cst == pas_pkg::CL_IDLE && !q.ctrl[0] |=> q.cst == pas_pkg::CL_IDLE)
        else $error("cleaning ran while disabled");
    c_clean_done: cover property (q.cst == pas_pkg::CL_REV ##1 q.cst == pas_pkg::CL_IDLE && trig);
    c_jockey_on: cover property (mode == 2'h2 ##1 $rose(jockey_o));
    c_prime_run: cover property (q.pst == pas_pkg::PR_PRIME ##1 q.pst == pas_pkg::PR_RUN);
endmodule : pas_sequencer

/* pkg/pas_params.svh */
// Register map, reset values and timing counts of the pump sequencer
`ifndef PAS_PARAMS_SVH
`define PAS_PARAMS_SVH
`define PAS_ADDR_CTRL 8'h00
`define PAS_ADDR_CYCLES 8'h04
`define PAS_ADDR_FWD_FREQ 8'h08
`define PAS_ADDR_FWD_TIME 8'h0c
`define PAS_ADDR_REV_FREQ 8'h10
`define PAS_ADDR_REV_TIME 8'h14
`define PAS_ADDR_ACC_TIME 8'h18
`define PAS_ADDR_DEC_TIME 8'h1c
`define PAS_ADDR_JSTART 8'h20
`define PAS_ADDR_JSTOP 8'h24
`define PAS_ADDR_PRIME_TIME 8'h28
`define PAS_ADDR_STATUS 8'h2c
`define PAS_CTRL_CLEAN_EN 0
`define PAS_CTRL_TRIG_LSB 1
`define PAS_CTRL_MODE_LSB 3
`define PAS_CTRL_PRIME_EN 5
`define PAS_RST_CYCLES 7'h05
`define PAS_MIN_CYCLES 7'h01
`define PAS_MAX_CYCLES 7'h64
`define PAS_RST_FREQ 13'h1194
`define PAS_MAX_FREQ 13'h1388
`define PAS_RST_FWD_TIME 15'h00c8
`define PAS_RST_REV_TIME 15'h0000
`define PAS_MAX_TIME 15'h7d00
`define PAS_RST_RAMP 12'h001
`define PAS_MIN_RAMP 12'h001
`define PAS_MAX_RAMP 12'hbb8
`define PAS_MAX_LEVEL 14'h2710
`define PAS_RST_PRIME 12'h01e
`define PAS_MAX_PRIME 12'hc80
`define PAS_PRIME_SCALE 4'ha
`define PAS_CLK_PERIOD_NS 4
`define PAS_TICK_TIME_NS 10000000
`define PAS_TICK_CYCLES (`PAS_TICK_TIME_NS / `PAS_CLK_PERIOD_NS)
`endif

/* pkg/pas_pkg.sv */
// Types of the pump sequencer
package pas_pkg;
    typedef enum logic [2:0] {CL_IDLE = 3'h1, CL_FWD = 3'h2, CL_REV = 3'h4} pas_clean_st_t;
    typedef enum logic [2:0] {PR_IDLE = 3'h1, PR_PRIME = 3'h2, PR_RUN = 3'h4} pas_prime_st_t;
    typedef struct packed {
        logic [5:0] ctrl;
        logic [6:0] cycles;
        logic [12:0] fwd_freq;
        logic [14:0] fwd_time;
        logic [12:0] rev_freq;
        logic [14:0] rev_time;
        logic [11:0] acc_time;
        logic [11:0] dec_time;
        logic [13:0] jstart;
        logic [13:0] jstop;
        logic [11:0] prime_time;
        logic aw_held, w_held, awready, wready, bvalid, arready, rvalid;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic [3:0] din_s1, din_s2;
        logic run_s1, run_s2, sleep_s1, sleep_s2, trig_prev;
        logic [13:0] fb;
        logic [21:0] div;
        logic tick;
        pas_clean_st_t cst;
        logic [14:0] timer;
        logic [6:0] cyc_done;
        pas_prime_st_t pst;
        logic [15:0] ptimer;
        logic drive_run, clean_act, rev_out, ramp_sel, jockey, prime, main_run;
        logic [12:0] freq_out;
        logic [11:0] ramp_acc, ramp_dec;
    } pas_state_t;
endpackage : pas_pkg

/* verif/pas_drive_model.sv */
// Far-side model: drive setpoint path and pump relay summary
`timescale 1ns/100ps
module pas_drive_model (
    // Commands from the sequencer
    input wire logic drive_run_i,
    input wire logic main_run_i,
    input wire logic reverse_i,
    input wire logic [12:0] freq_ref_i,
    // Setpoint seen by the motor
    output logic motor_on_o,
    output logic signed [13:0] motor_freq_o
);
    // Reverse phase turns the setpoint negative; a stopped drive holds zero
    always_comb begin
        motor_on_o = drive_run_i || main_run_i;
        motor_freq_o = $signed({1'b0, freq_ref_i});
        if (!drive_run_i) begin
            motor_freq_o = 14'sh0;
        end else if (reverse_i) begin
            motor_freq_o = -$signed({1'b0, freq_ref_i});
        end
    end
endmodule : pas_drive_model

/* verif/test_pas_sequencer.sv */
// Testbench of the pump sequencer: registers, cleaning, jockey and priming
`timescale 1ns/100ps
module test_pas_sequencer;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] dig_in = 4'h0;
    logic run_cmd = 1'b0, sleep = 1'b0;
    logic [13:0] fb = 14'h0;
    logic drive_run, clean_act, rev, ramp_sel, jockey, prime, main_run, motor_on;
    logic [12:0] freq;
    logic [11:0] acc, dec;
    logic signed [13:0] motor_freq;
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h28};
    logic [31:0] rv [8] = '{32'h0, 32'h5, 32'h1194, 32'hc8, 32'h1194, 32'h0, 32'h1, 32'h1e};

    // Short timebase so a 0.01 s tick is four cycles
    pas_sequencer #(.TICK_CYCLES(4)) i_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .dig_in_i(dig_in), .run_cmd_i(run_cmd), .pid_sleep_i(sleep), .feedback_i(fb),
        .drive_run_o(drive_run), .clean_active_o(clean_act), .freq_ref_o(freq), .reverse_o(rev),
        .ramp_sel_o(ramp_sel), .ramp_acc_o(acc), .ramp_dec_o(dec), .jockey_o(jockey),
        .prime_pump_o(prime), .main_run_o(main_run)
    );

    pas_drive_model i_far (
        .drive_run_i(drive_run), .main_run_i(main_run), .reverse_i(rev), .freq_ref_i(freq),
        .motor_on_o(motor_on), .motor_freq_o(motor_freq)
    );

    // Clock, 4 ns period
    always #2 clk_i = ~clk_i;

    // Closing report and verdict
    task end_of_test;
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Output pins by index, so one wait loop serves them all
    function automatic logic pick(input int k);
        case (k)
            0: return clean_act;
            1: return drive_run;
            2: return rev;
            3: return ramp_sel;
            4: return jockey;
            5: return prime;
            default: return main_run;
        endcase
    endfunction : pick

    // Outputs are sampled at the falling edge, clear of the launching edge
    task wait_lvl(input int k, input logic v, input int lim);
        n = 0;
        @(negedge clk_i);
        while (pick(k) !== v) begin
            n++;
            if (n > lim) begin
                chk(32'h0, 32'h1);
                end_of_test();
            end
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask : wait_lvl

    task pin(input int k, input logic v);
        @(negedge clk_i);
        chk({31'h0, pick(k)}, {31'h0, v});
        @(posedge clk_i);
    endtask : pin

    // Write: address and data offered together, each dropped when taken
    task axi_wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
        logic ag, wg, bg;
        int t;
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bg = 1'b0;
        for (t = 0; t < 40 && !bg; t++) begin
            @(negedge clk_i);
            ag = awvalid && awready;
            wg = wvalid && wready;
            bg = bvalid;
            r = bresp;
            @(posedge clk_i);
            if (ag) awvalid <= 1'b0;
            if (wg) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!bg) begin
            chk(32'h0, 32'h1);
            end_of_test();
        end
        chk({30'h0, r}, {30'h0, er});
        @(posedge clk_i);
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ag, rg;
        int t;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rg = 1'b0;
        for (t = 0; t < 40 && !rg; t++) begin
            @(negedge clk_i);
            ag = arvalid && arready;
            rg = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_i);
            if (ag) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!rg) begin
            chk(32'h0, 32'h1);
            end_of_test();
        end
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
        @(posedge clk_i);
    endtask : axi_rd

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        foreach (ra[i]) axi_rd(ra[i], rv[i], 2'h0);
        axi_rd(8'h30, 32'h0, 2'h2);
        axi_rd(8'h2c, 32'h90, 2'h0);
        axi_wr(8'h2c, 32'h1, 2'h2);
        axi_wr(8'h04, 32'hc8, 2'h0);
        axi_rd(8'h04, 32'h64, 2'h0);
        axi_wr(8'h04, 32'h0, 2'h0);
        axi_rd(8'h04, 32'h1, 2'h0);
        axi_wr(8'h08, 32'h1770, 2'h0);
        axi_rd(8'h08, 32'h1388, 2'h0);
        // Activation while cleaning is disabled must do nothing; input 0 is the one selected now
        dig_in <= 4'h5;
        repeat (8) @(posedge clk_i);
        pin(0, 1'b0);
        dig_in <= 4'h0;
        axi_wr(8'h04, 32'h2, 2'h0);
        axi_wr(8'h08, 32'h3e8, 2'h0);
        axi_wr(8'h0c, 32'h3, 2'h0);
        axi_wr(8'h10, 32'h7d0, 2'h0);
        axi_wr(8'h14, 32'h2, 2'h0);
        axi_wr(8'h18, 32'h32, 2'h0);
        axi_wr(8'h1c, 32'h28, 2'h0);
        axi_wr(8'h00, 32'h5, 2'h0);
        // Two forward/reverse cycles from input 2
        dig_in <= 4'h4;
        wait_lvl(0, 1'b1, 8);
        @(negedge clk_i);
        chk({31'h0, drive_run}, 32'h1);
        chk({19'h0, freq}, 32'h3e8);
        chk({31'h0, motor_on}, 32'h1);
        wait_lvl(2, 1'b1, 30);
        chk(32'(n >= 8 && n <= 18), 32'h1);
        @(negedge clk_i);
        chk(32'(motor_freq), 32'hfffff830);
        chk({31'h0, ramp_sel}, 32'h1);
        chk({20'h0, acc}, 32'h32);
        chk({20'h0, dec}, 32'h28);
        wait_lvl(2, 1'b0, 20);
        wait_lvl(2, 1'b1, 30);
        wait_lvl(2, 1'b0, 20);
        wait_lvl(0, 1'b0, 3);
        // Release part way through a new run
        dig_in <= 4'h0;
        repeat (6) @(posedge clk_i);
        dig_in <= 4'h4;
        wait_lvl(0, 1'b1, 8);
        repeat (2) @(posedge clk_i);
        dig_in <= 4'h0;
        wait_lvl(0, 1'b0, 5);
        pin(1, 1'b0);
        // Jockey modes 0, 1 and 2
        fb <= 14'h1388;
        axi_wr(8'h20, 32'hbb8, 2'h0);
        axi_wr(8'h24, 32'h1b58, 2'h0);
        axi_wr(8'h00, 32'h18, 2'h0);
        axi_rd(8'h00, 32'h0, 2'h0);
        axi_wr(8'h00, 32'h0, 2'h0);
        sleep <= 1'b1;
        repeat (8) @(posedge clk_i);
        pin(4, 1'b0);
        axi_wr(8'h00, 32'h8, 2'h0);
        wait_lvl(4, 1'b1, 8);
        fb <= 14'h2328;
        repeat (8) @(posedge clk_i);
        pin(4, 1'b1);
        sleep <= 1'b0;
        wait_lvl(4, 1'b0, 6);
        axi_wr(8'h00, 32'h10, 2'h0);
        fb <= 14'h1388;
        sleep <= 1'b1;
        repeat (8) @(posedge clk_i);
        pin(4, 1'b0);
        fb <= 14'h7d0;
        wait_lvl(4, 1'b1, 4);
        fb <= 14'h1388;
        repeat (8) @(posedge clk_i);
        pin(4, 1'b1);
        fb <= 14'h1f40;
        wait_lvl(4, 1'b0, 4);
        fb <= 14'h7d0;
        wait_lvl(4, 1'b1, 4);
        sleep <= 1'b0;
        wait_lvl(4, 1'b0, 6);
        // Priming for 0.1 s, that is ten ticks
        axi_wr(8'h28, 32'h1, 2'h0);
        axi_wr(8'h00, 32'h20, 2'h0);
        run_cmd <= 1'b1;
        wait_lvl(5, 1'b1, 6);
        pin(6, 1'b0);
        wait_lvl(6, 1'b1, 60);
        chk(32'(n >= 34 && n <= 46), 32'h1);
        pin(5, 1'b0);
        run_cmd <= 1'b0;
        wait_lvl(6, 1'b0, 6);
        axi_wr(8'h00, 32'h0, 2'h0);
        run_cmd <= 1'b1;
        wait_lvl(6, 1'b1, 6);
        pin(5, 1'b0);
        end_of_test();
    end
endmodule : test_pas_sequencer
